// File: rtl/sd_port_regs.svh
// Register offsets, field positions and reset values of the serial result output port
`ifndef SD_PORT_REGS_SVH
`define SD_PORT_REGS_SVH

// Byte addresses on the register bus
`define SD_CTRL_OFFSET        12'h000
`define SD_TMDELAY_OFFSET     12'h004
`define SD_STATUS_OFFSET      12'h008

// Control register fields
`define SD_CTRL_LANES_LSB     0
`define SD_CTRL_LANES_MSB     1
`define SD_CTRL_RESET         2'h0

// Timing mark delay register
`define SD_TMDELAY_WIDTH      24
`define SD_TMDELAY_RESET      24'h000000

// Status register fields
`define SD_STAT_COUNT_LSB     0
`define SD_STAT_COUNT_MSB     3
`define SD_STAT_BUSY_BIT      4
`define SD_STAT_TMPEND_BIT    5
`define SD_STAT_TMRUN_BIT     6

// Output word layout
`define SD_WORD_WIDTH         32
`define SD_DATA_WIDTH         24
`define SD_FAULT_BIT          31
`define SD_LANE_MSB           30
`define SD_LANE_LSB           29
`define SD_TMARK_BIT          28
`define SD_OVR_BIT            27
`define SD_LAST_BIT_INDEX     6'h1F

`endif

// File: rtl/sd_port_pkg.sv
// Types shared by the serial result output port
package sd_port_pkg;

  typedef logic [1:0]  lane_t;
  typedef logic [23:0] sample_t;
  typedef logic [31:0] word_t;

  // Transaction states; only ST_IDLE to ST_SHIFT and ST_SHIFT to ST_FINISH change a single bit
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_SHIFT  = 2'b01,
    ST_FINISH = 2'b11
  } xfer_state_t;

endpackage

// File: rtl/sd_sync.sv
// Two-flop synchroniser for a group of asynchronous levels
`timescale 1ns/1ns
module sd_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_reg;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1_reg <= '0;
      sync_out   <= '0;
    end else begin
      stage1_reg <= async_in;
      sync_out   <= stage1_reg;
    end
  end

endmodule

// File: rtl/sd_fifo.sv
// Word FIFO that drops its oldest entry when written while full
`timescale 1ns/1ns
module sd_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 8
) (
  input  wire logic                   pclk,
  input  wire logic                   presetn,
  input  wire logic                   push,
  input  wire logic [WIDTH-1:0]       push_data,
  input  wire logic                   pop,
  output logic      [WIDTH-1:0]       head_data,
  output logic                        empty,
  output logic                        full,
  output logic      [$clog2(DEPTH):0] count
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic [AW-1:0]    wr_ptr_next;
  logic [AW-1:0]    rd_ptr_next;
  logic [AW:0]      count_next;
  logic             do_pop;
  logic             drop_oldest;

  // Pointer and count update; a push into a full FIFO overwrites the oldest
  always_comb begin
    do_pop      = pop && (count_reg != '0);
    drop_oldest = push && !do_pop && (count_reg == (AW+1)'(DEPTH));
    wr_ptr_next = wr_ptr_reg;
    rd_ptr_next = rd_ptr_reg;
    count_next  = count_reg;
    if (push) begin
      wr_ptr_next = (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + AW'(1);
    end
    if (do_pop || drop_oldest) begin
      rd_ptr_next = (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + AW'(1);
    end
    if (push && !do_pop && !drop_oldest) begin
      count_next = count_reg + (AW+1)'(1);
    end else if (do_pop && !push) begin
      count_next = count_reg - (AW+1)'(1);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_next;
      rd_ptr_reg <= rd_ptr_next;
      count_reg  <= count_next;
    end
  end

  // Storage has no reset; the count guards every read
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_reg] <= push_data;
    end
  end

  assign head_data = mem[rd_ptr_reg];
  assign empty     = (count_reg == '0);
  assign full      = (count_reg == (AW+1)'(DEPTH));
  assign count     = count_reg;

endmodule

// File: rtl/serial_result_output_port.sv
// Serial result output port: status tagging, word FIFO, token-started serial shift-out, APB registers
`timescale 1ns/1ns
`include "sd_port_regs.svh"
module serial_result_output_port #(
  parameter int FIFO_DEPTH = 8,
  parameter int LANES      = 4
) (
  input  wire logic                 pclk,
  input  wire logic                 presetn,
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [11:0]          paddr,
  input  wire logic [31:0]          pwdata,
  output logic      [31:0]          prdata,
  output logic                      pready,
  output logic                      pslverr,
  input  wire logic                 sample_valid,
  input  wire sd_port_pkg::sample_t sample_data,
  input  wire sd_port_pkg::lane_t   sample_lane,
  input  wire logic [LANES-1:0]     modulator_fault_inputs,
  input  wire logic                 timing_ref_in,
  input  wire logic                 token_in,
  input  wire logic                 serial_clock_in,
  output logic                      data_ready_n,
  output logic                      serial_out,
  output logic                      token_out
);
  import sd_port_pkg::*;

  localparam int CW = $clog2(FIFO_DEPTH) + 1;

  // Lane enable decode, shared by sample gating and timing marks
  function automatic logic lane_enabled(input logic [1:0] setting, input lane_t lane);
    lane_enabled = (setting == 2'h0) ? 1'b1 : (lane < setting);
  endfunction

  // ---------------- Synchronisers and edge detection ----------------
  logic [LANES-1:0] fault_s;
  logic             tok_s;
  logic             sclk_s;
  logic             tref_s;
  logic             tok_d_reg;
  logic             sclk_d_reg;
  logic             tref_d_reg;
  logic             tok_rise;
  logic             sclk_rise;
  logic             sclk_fall;
  logic             tref_rise;

  sd_sync #(.WIDTH(LANES + 3)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({modulator_fault_inputs, timing_ref_in, token_in, serial_clock_in}),
    .sync_out ({fault_s, tref_s, tok_s, sclk_s})
  );

  // Delayed copies of the synchronised levels for edge finding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tok_d_reg  <= 1'b0;
      sclk_d_reg <= 1'b0;
      tref_d_reg <= 1'b0;
    end else begin
      tok_d_reg  <= tok_s;
      sclk_d_reg <= sclk_s;
      tref_d_reg <= tref_s;
    end
  end

  assign tok_rise  = tok_s && !tok_d_reg;
  assign sclk_rise = sclk_s && !sclk_d_reg;
  assign sclk_fall = !sclk_s && sclk_d_reg;
  assign tref_rise = tref_s && !tref_d_reg;

  // ---------------- Register file state ----------------
  logic [1:0]                    lanes_cfg_reg;
  logic [`SD_TMDELAY_WIDTH-1:0]  tm_delay_reg;

  // ---------------- Sample tagging and timing mark ----------------
  logic                          accept;
  logic [`SD_TMDELAY_WIDTH-1:0]  tm_count_reg;
  logic [`SD_TMDELAY_WIDTH-1:0]  tm_count_next;
  logic                          tm_run_reg;
  logic                          tm_run_next;
  logic [LANES-1:0]              tm_pend_reg;
  logic [LANES-1:0]              tm_pend_next;
  logic [LANES-1:0]              enabled_mask;
  logic [LANES-1:0]              tm_set;
  logic [LANES-1:0]              tm_clear;
  logic                          word_mark;
  logic                          overrun;
  word_t                         push_word;
  word_t                         head_word;
  logic                          fifo_empty;
  logic                          fifo_full;
  logic [CW-1:0]                 fifo_count;
  logic                          fifo_pop;

  // Enabled lane mask from the lane setting
  // lane enable decode
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      enabled_mask[i] = lane_enabled(lanes_cfg_reg, lane_t'(i));
    end
  end

  // Samples of disabled lanes are discarded
  assign accept = sample_valid && lane_enabled(lanes_cfg_reg, sample_lane);

  // Delay counts accepted first-lane samples after the reference edge
  // timing mark arming
  always_comb begin
    tm_count_next = tm_count_reg;
    tm_run_next   = tm_run_reg;
    tm_set        = '0;
    if (tref_rise) begin
      if (tm_delay_reg == '0) begin
        tm_set      = enabled_mask;
        tm_run_next = 1'b0;
      end else begin
        tm_count_next = tm_delay_reg;
        tm_run_next   = 1'b1;
      end
    end else if (tm_run_reg && accept && (sample_lane == 2'h0)) begin
      tm_count_next = tm_count_reg - `SD_TMDELAY_WIDTH'(1);
      if (tm_count_reg == `SD_TMDELAY_WIDTH'(1)) begin
        tm_set      = enabled_mask;
        tm_run_next = 1'b0;
      end
    end
  end

  // One marked word per lane; a new set beats the clear
  // self-clearing mark
  always_comb begin
    tm_clear = '0;
    if (accept) begin
      tm_clear[sample_lane] = 1'b1;
    end
    tm_pend_next = (tm_pend_reg & ~tm_clear) | tm_set;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tm_count_reg <= `SD_TMDELAY_RESET;
      tm_run_reg   <= 1'b0;
      tm_pend_reg  <= '0;
    end else begin
      tm_count_reg <= tm_count_next;
      tm_run_reg   <= tm_run_next;
      tm_pend_reg  <= tm_pend_next;
    end
  end

  // Overrun when a push lands on a full FIFO with no pop to make room
  // overrun flag
  assign overrun   = accept && fifo_full && !fifo_pop;
  assign word_mark = tm_pend_reg[sample_lane];

  // Word assembly: fault, lane, mark, overrun, three zero bits, data
  // status byte plus sample
  // fault taken straight from the synchronised lane input
  always_comb begin
    push_word                              = '0;
    push_word[`SD_DATA_WIDTH-1:0]          = sample_data;
    push_word[`SD_FAULT_BIT]               = fault_s[sample_lane];
    push_word[`SD_LANE_MSB:`SD_LANE_LSB]   = sample_lane;
    push_word[`SD_TMARK_BIT]               = word_mark;
    push_word[`SD_OVR_BIT]                 = overrun;
  end

  sd_fifo #(.WIDTH(`SD_WORD_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .push      (accept),
    .push_data (push_word),
    .pop       (fifo_pop),
    .head_data (head_word),
    .empty     (fifo_empty),
    .full      (fifo_full),
    .count     (fifo_count)
  );

  // ---------------- Serial transaction engine ----------------
  xfer_state_t state_reg;
  xfer_state_t state_next;
  word_t       shift_reg;
  word_t       shift_next;
  logic [5:0]  bit_cnt_reg;
  logic [5:0]  bit_cnt_next;
  logic        rise_seen_reg;
  logic        rise_seen_next;
  logic        ready_n_reg;
  logic        ready_n_next;
  logic        tok_out_reg;
  logic        tok_out_next;
  logic        sout_reg;
  logic        sout_next;

  // Next word is loaded right after the last rising edge so the MSB is set before the next rise
  always_comb begin
    state_next     = state_reg;
    shift_next     = shift_reg;
    bit_cnt_next   = bit_cnt_reg;
    rise_seen_next = rise_seen_reg;
    ready_n_next   = ready_n_reg;
    tok_out_next   = 1'b0;
    sout_next      = sout_reg;
    fifo_pop       = 1'b0;
    case (state_reg)
      ST_IDLE: begin
        if (tok_rise) begin
          if (!fifo_empty) begin
            fifo_pop       = 1'b1;
            shift_next     = head_word;
            sout_next      = head_word[`SD_WORD_WIDTH-1];
            bit_cnt_next   = '0;
            rise_seen_next = 1'b0;
            ready_n_next   = 1'b0;
            state_next     = ST_SHIFT;
          end else begin
            tok_out_next = 1'b1;
            state_next   = ST_FINISH;
          end
        end
      end
      ST_SHIFT: begin
        if (sclk_rise) begin
          rise_seen_next = 1'b1;
          bit_cnt_next   = bit_cnt_reg + 6'h01;
          if (bit_cnt_reg == `SD_LAST_BIT_INDEX) begin
            if (!fifo_empty) begin
              fifo_pop       = 1'b1;
              shift_next     = head_word;
              sout_next      = head_word[`SD_WORD_WIDTH-1];
              bit_cnt_next   = '0;
              rise_seen_next = 1'b0;
            end else begin
              ready_n_next = 1'b1;
              tok_out_next = 1'b1;
              state_next   = ST_FINISH;
            end
          end
        end else if (sclk_fall && rise_seen_reg) begin
          // MSB first, change on falling edge
          shift_next = {shift_reg[`SD_WORD_WIDTH-2:0], 1'b0};
          sout_next  = shift_reg[`SD_WORD_WIDTH-2];
        end
      end
      ST_FINISH: begin
        state_next = ST_IDLE;
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= '0;
      bit_cnt_reg   <= '0;
      rise_seen_reg <= 1'b0;
      ready_n_reg   <= 1'b1;
      tok_out_reg   <= 1'b0;
      sout_reg      <= 1'b0;
    end else begin
      state_reg     <= state_next;
      shift_reg     <= shift_next;
      bit_cnt_reg   <= bit_cnt_next;
      rise_seen_reg <= rise_seen_next;
      ready_n_reg   <= ready_n_next;
      tok_out_reg   <= tok_out_next;
      sout_reg      <= sout_next;
    end
  end

  assign data_ready_n = ready_n_reg;
  assign token_out    = tok_out_reg;
  assign serial_out   = sout_reg;

  // ---------------- APB slave ----------------
  logic [1:0]                   lanes_cfg_next;
  logic [`SD_TMDELAY_WIDTH-1:0] tm_delay_next;
  logic                         pready_reg;
  logic                         pready_next;
  logic [31:0]                  prdata_reg;
  logic [31:0]                  prdata_next;
  logic                         pslverr_reg;
  logic                         pslverr_next;
  logic                         wr_fire;
  logic                         mapped;

  // Fixed one wait state keeps read data a clean flop output
  always_comb begin
    lanes_cfg_next = lanes_cfg_reg;
    tm_delay_next  = tm_delay_reg;
    pready_next    = psel && penable && !pready_reg;
    prdata_next    = prdata_reg;
    pslverr_next   = 1'b0;
    wr_fire        = psel && penable && pready_reg && pwrite;
    mapped         = 1'b1;
    if (paddr == `SD_CTRL_OFFSET) begin
      prdata_next = {30'h00000000, lanes_cfg_reg};
      if (wr_fire) begin
        lanes_cfg_next = pwdata[`SD_CTRL_LANES_MSB:`SD_CTRL_LANES_LSB];
      end
    end else if (paddr == `SD_TMDELAY_OFFSET) begin
      prdata_next = {8'h00, tm_delay_reg};
      if (wr_fire) begin
        tm_delay_next = pwdata[`SD_TMDELAY_WIDTH-1:0];
      end
    end else if (paddr == `SD_STATUS_OFFSET) begin
      prdata_next                                          = '0;
      prdata_next[`SD_STAT_COUNT_MSB:`SD_STAT_COUNT_LSB]  = 4'(fifo_count);
      prdata_next[`SD_STAT_BUSY_BIT]                       = !ready_n_reg;
      prdata_next[`SD_STAT_TMPEND_BIT]                     = |tm_pend_reg;
      prdata_next[`SD_STAT_TMRUN_BIT]                      = tm_run_reg;
    end else begin
      mapped      = 1'b0;
      prdata_next = '0;
    end
    if (pwrite || !pready_next) begin
      prdata_next = pwrite ? 32'h00000000 : prdata_reg;
    end
    if (pready_next) begin
      pslverr_next = !mapped;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lanes_cfg_reg <= `SD_CTRL_RESET;
      tm_delay_reg  <= `SD_TMDELAY_RESET;
      pready_reg    <= 1'b0;
      prdata_reg    <= 32'h00000000;
      pslverr_reg   <= 1'b0;
    end else begin
      lanes_cfg_reg <= lanes_cfg_next;
      tm_delay_reg  <= tm_delay_next;
      pready_reg    <= pready_next;
      prdata_reg    <= prdata_next;
      pslverr_reg   <= pslverr_next;
    end
  end

  assign pready  = pready_reg;
  assign prdata  = prdata_reg;
  assign pslverr = pslverr_reg;

endmodule

// File: testbench/sd_port_asserts.sv
// Concurrent checks on the APB handshake and the link side of the serial result output port
`timescale 1ns/1ns
module sd_port_asserts (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic token_in,
  input wire logic serial_clock_in,
  input wire logic data_ready_n,
  input wire logic token_out
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Token request seen while idle, and the answer it must draw
  sequence tok_req;
    $rose(token_in) && data_ready_n;
  endsequence
  sequence tok_answer;
    ##[2:6] (!data_ready_n || token_out);
  endsequence

  apb_wait_a: assert property (psel && !penable |-> ##2 pready)
    else $error("register access not answered after one wait state");
  start_resp_a: assert property (tok_req |-> tok_answer)
    else $error("token edge drew no transaction and no token pulse");
  // Synchroniser means no answer on the very next cycle
  sync_delay_a: assert property ($rose(token_in) |=> data_ready_n && !token_out)
    else $error("token edge answered before synchronisation");
  low_hold_a: assert property ($fell(data_ready_n) |-> (!data_ready_n) [*8])
    else $error("ready dropped early in a transaction");
  ready_end_a: assert property ($rose(data_ready_n) |-> $past(serial_clock_in, 2))
    else $error("ready released without a serial clock rise");
  end_token_a: assert property ($rose(data_ready_n) |-> token_out)
    else $error("end of transaction without token pulse");
  token_idle_a: assert property (token_out |-> data_ready_n)
    else $error("token pulse while ready is low");
  token_pulse_a: assert property (token_out |=> !token_out)
    else $error("token pulse longer than one clock");
endmodule

bind serial_result_output_port sd_port_asserts u_sd_port_asserts (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .token_in(token_in),
  .serial_clock_in(serial_clock_in), .data_ready_n(data_ready_n), .token_out(token_out));

// File: testbench/sd_controller_model.sv
// Communications controller model: token requests and serial word capture
`timescale 1ns/1ns
module sd_controller_model (
  input  wire logic pclk,
  input  wire logic data_ready_n,
  input  wire logic serial_out,
  input  wire logic token_out,
  output logic      token_in,
  output logic      serial_clock_in
);
  logic [31:0] words[$];
  int          tok_seen;

  // Link clock idles low between frames
  initial begin
    token_in = 1'h0;
    serial_clock_in = 1'h0;
    tok_seen = 0;
  end

  always @(posedge pclk) begin
    if (token_out === 1'h1) tok_seen++;
  end

  // Clock words out while ready is low; bounded so a stuck ready cannot hang
  task automatic shift_words();
    logic [31:0] w;
    while (data_ready_n === 1'h0 && words.size() < 12) begin
      for (int i = 0; i < 32; i++) begin
        serial_clock_in <= 1'h1;
        repeat (2) @(posedge pclk);
        // bit taken just after the rise, MSB first
        w = {w[30:0], serial_out};
        repeat (2) @(posedge pclk);
        serial_clock_in <= 1'h0;
        repeat (4) @(posedge pclk);
      end
      words.push_back(w);
    end
  endtask

  // continuous mode: 320 ns token train, inside the 4 MHz limit
  // train raised only while ready is high, as the outside gate does
  task automatic stream(input int periods);
    for (int p = 0; p < periods; p++) begin
      token_in <= data_ready_n;
      repeat (8) @(posedge pclk);
      token_in <= 1'h0;
      repeat (8) @(posedge pclk);
      shift_words();
    end
  endtask

  // next request only after ready returns high
  task automatic poll(output logic hung);
    int          n;
    int          b;
    n = tok_seen;
    token_in <= 1'h1;
    repeat (2) @(posedge pclk);
    token_in <= 1'h0;
    b = 0;
    while (data_ready_n !== 1'h0 && tok_seen == n && b < 20) begin
      @(posedge pclk);
      b++;
    end
    hung = (b >= 20);
    shift_words();
    if (words.size() >= 12) hung = 1'h1;
  endtask
endmodule

// File: testbench/tb.sv
// Self-checking bench of the serial result output port
`timescale 1ns/1ns
`include "sd_port_regs.svh"
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("Error at %0t: got %h want %h", $time, g, e); end end
module tb;
  import sd_port_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, sample_valid, err, hung;
  logic        timing_ref_in, token_in, serial_clock_in, data_ready_n, serial_out, token_out;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  modulator_fault_inputs;
  sample_t     sample_data;
  lane_t       sample_lane;
  word_t       exp_q[$];
  int          miscompares = 0;
  int          compares = 0;

  serial_result_output_port u_serial_result_output_port (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_valid(sample_valid), .sample_data(sample_data), .sample_lane(sample_lane),
    .modulator_fault_inputs(modulator_fault_inputs), .timing_ref_in(timing_ref_in), .token_in(token_in),
    .serial_clock_in(serial_clock_in), .data_ready_n(data_ready_n), .serial_out(serial_out),
    .token_out(token_out));
  sd_controller_model u_sd_controller_model (.pclk(pclk), .data_ready_n(data_ready_n),
    .serial_out(serial_out), .token_out(token_out), .token_in(token_in), .serial_clock_in(serial_clock_in));

  initial begin
    pclk = 1'h0;
    forever #10 pclk = ~pclk;
  end

  task automatic results();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // One APB transfer; waits for pready under a bound
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'h1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      results();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask

  task automatic push(input lane_t l, input sample_t d);
    sample_valid <= 1'h1;
    sample_lane <= l;
    sample_data <= d;
    @(posedge pclk);
    sample_valid <= 1'h0;
    @(posedge pclk);
  endtask

  function automatic word_t wd(logic f, lane_t l, logic m, logic o, sample_t d);
    return {f, l, m, o, 3'h0, d};
  endfunction

  // Poll once and compare captured words and the end pulse
  task automatic drain(input string s);
    int t;
    t = u_sd_controller_model.tok_seen;
    u_sd_controller_model.words.delete();
    u_sd_controller_model.poll(hung);
    if (hung) begin
      miscompares++;
      results();
    end
    `CHK(u_sd_controller_model.tok_seen - t, 1)
    `CHK(u_sd_controller_model.words.size(), exp_q.size())
    foreach (exp_q[i]) `CHK(u_sd_controller_model.words[i], exp_q[i])
    exp_q.delete();
    $display("Test %s done", s);
  endtask

  task automatic t_regs();
    `CHK({data_ready_n, token_out, serial_out}, 3'h4)
    apb(1'h0, `SD_CTRL_OFFSET, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h1, `SD_TMDELAY_OFFSET, 32'hFFFFFFFF);
    apb(1'h0, `SD_TMDELAY_OFFSET, 32'h0);
    `CHK(rd, 32'h00FFFFFF)
    apb(1'h1, `SD_STATUS_OFFSET, 32'hFF);
    `CHK(err, 1'h0)
    apb(1'h0, `SD_STATUS_OFFSET, 32'h0);
    `CHK(rd, 32'h0)
    apb(1'h0, 12'h00C, 32'h0);
    `CHK({err, rd}, 33'h100000000)
    $display("Test registers done");
  endtask

  // Fault on the third lane only, all lanes enabled
  task automatic t_tag();
    modulator_fault_inputs <= 4'h4;
    repeat (4) @(posedge pclk);
    for (int i = 0; i < 4; i++) begin
      push(lane_t'(i), 24'h800010 + 24'(i));
      exp_q.push_back(wd(i == 2, lane_t'(i), 1'h0, 1'h0, 24'h800010 + 24'(i)));
    end
    modulator_fault_inputs <= 4'h0;
    drain("lane tagging");
  endtask

  task automatic t_enable();
    for (int s = 1; s < 4; s++) begin
      apb(1'h1, `SD_CTRL_OFFSET, 32'(s));
      for (int i = 0; i < 4; i++) begin
        push(lane_t'(i), 24'(i));
        if (i < s) exp_q.push_back(wd(1'h0, lane_t'(i), 1'h0, 1'h0, 24'(i)));
      end
      drain("lane enable");
    end
    apb(1'h1, `SD_CTRL_OFFSET, 32'h0);
  endtask

  // Nine words into eight places: oldest lost, newest flagged
  task automatic t_over();
    for (int i = 0; i < 9; i++) push(2'h1, 24'(i));
    apb(1'h0, `SD_STATUS_OFFSET, 32'h0);
    `CHK(rd[3:0], 4'h8)
    for (int i = 1; i < 9; i++) exp_q.push_back(wd(1'h0, 2'h1, 1'h0, i == 8, 24'(i)));
    drain("overrun");
  endtask

  // Delay 0 marks the next four words, delay 1 skips the first lane-0 word
  task automatic t_mark();
    for (int d = 0; d < 2; d++) begin
      apb(1'h1, `SD_TMDELAY_OFFSET, 32'(d));
      timing_ref_in <= 1'h1;
      repeat (6) @(posedge pclk);
      timing_ref_in <= 1'h0;
      for (int i = 0; i < 8; i++) begin
        push(lane_t'(i % 4), 24'(i));
        exp_q.push_back(wd(1'h0, lane_t'(i % 4), i >= d && i < d + 4, 1'h0, 24'(i)));
      end
      drain("timing mark");
    end
  endtask

  // Continuous mode: first token drains two words, the next two find the FIFO empty
  task automatic t_stream();
    int t;
    t = u_sd_controller_model.tok_seen;
    u_sd_controller_model.words.delete();
    push(2'h0, 24'h7FFFFF);
    push(2'h3, 24'h000001);
    exp_q.push_back(wd(1'h0, 2'h0, 1'h0, 1'h0, 24'h7FFFFF));
    exp_q.push_back(wd(1'h0, 2'h3, 1'h0, 1'h0, 24'h000001));
    u_sd_controller_model.stream(3);
    `CHK(u_sd_controller_model.tok_seen - t, 3)
    `CHK(u_sd_controller_model.words.size(), 2)
    foreach (exp_q[i]) `CHK(u_sd_controller_model.words[i], exp_q[i])
    exp_q.delete();
    $display("Test continuous mode done");
  endtask

  initial begin
    presetn = 1'h0;
    psel = 1'h0;
    penable = 1'h0;
    pwrite = 1'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    sample_valid = 1'h0;
    sample_data = 24'h0;
    sample_lane = 2'h0;
    modulator_fault_inputs = 4'h0;
    timing_ref_in = 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    t_regs();
    drain("empty token");
    t_tag();
    t_enable();
    t_over();
    t_mark();
    t_stream();
    results();
  end
endmodule
